// ### logic/pstr_regs.svh
// Purpose: Command codes, field positions, reset values and fixed figures
// Assumes: Included by bare name from the design files
// Notes:   Definitions only
`ifndef PSTR_REGS_SVH
`define PSTR_REGS_SVH

// ****************************************
// Command codes
// ****************************************
`define PSTR_CMD_CLEAR_FAULTS     8'h03
`define PSTR_CMD_EXT_TEMP_STATUS  8'h7D
`define PSTR_CMD_COMM_FAULT       8'h7E
`define PSTR_CMD_VENDOR_FAULT     8'h80
`define PSTR_CMD_VOUT_READBACK    8'h8B
`define PSTR_CMD_IOUT_READBACK    8'h8C
`define PSTR_CMD_TEMP_READBACK    8'h8E

// ****************************************
// Status byte fields
// ****************************************
`define PSTR_TEMP_FAULT_BIT       7
`define PSTR_TEMP_WARN_BIT        6
`define PSTR_CML_IVC_BIT          7
`define PSTR_CML_IVD_BIT          6
`define PSTR_CML_PEC_BIT          5
`define PSTR_CML_MEM_BIT          4
`define PSTR_CML_OTH_BIT          1
`define PSTR_VND_TSD_BIT          7
`define PSTR_VND_ZERO_BIT         6
`define PSTR_VND_MULTI_BIT        5
`define PSTR_VND_VSTRAP_BIT       4
`define PSTR_VND_SSTRAP_BIT       3
`define PSTR_VND_RSTREQ_BIT       2
`define PSTR_VND_VMIN_BIT         1

// Bits that a write of 1 clears
`define PSTR_TEMP_W1C_MASK        8'hC0
`define PSTR_CML_W1C_MASK         8'hF2
`define PSTR_VND_W1C_MASK         8'h9A
// Bits that the clear-faults command clears
`define PSTR_VND_CLRALL_MASK      8'hFA
// Bits that may raise the alert line
`define PSTR_TEMP_ALERT_MASK      8'hC0
`define PSTR_CML_ALERT_MASK       8'hF2
`define PSTR_VND_ALERT_MASK       8'h82

// ****************************************
// Reset values and fixed figures
// ****************************************
`define PSTR_STATUS_RESET         8'h00
`define PSTR_VOUT_RESET           16'h0000
`define PSTR_IOUT_EXPONENT        5'h1C
`define PSTR_TEMP_EXPONENT        5'h00
`define PSTR_TEMP_RESET_MANT      11'h019
`define PSTR_TEMP_HYST_DEGC       12'h014
`define PSTR_IOUT_MAX_COUNTS      12'h280

`endif

// ### logic/pstr_pkg.sv
// Purpose: Types shared by the status and telemetry register bank
// Assumes: Nothing
// Notes:   Numbers live in pstr_regs.svh
package pstr_pkg;

  typedef enum logic [2:0] {
    PSTR_SEL_NONE   = 3'b000,
    PSTR_SEL_CLEAR  = 3'b001,
    PSTR_SEL_TEMP   = 3'b010,
    PSTR_SEL_CML    = 3'b011,
    PSTR_SEL_VENDOR = 3'b100,
    PSTR_SEL_VOUT   = 3'b101,
    PSTR_SEL_IOUT   = 3'b110,
    PSTR_SEL_TRB    = 3'b111
  } pstr_sel_type;

endpackage

// ### logic/pstr_link_port.sv
// Purpose: Link-clock end of the command port, toggle handshake to system side
// Assumes: linkClk runs while a command is outstanding
// Notes:   One command in flight; cmdReady low until the answer returns
`timescale 1ns/1ps
`default_nettype none

module pstr_link_port (
  // Clock and reset
  input  wire logic        linkClk,
  input  wire logic        rst,
  // Command side
  input  wire logic        cmdValid,
  input  wire logic [7:0]  cmdCode,
  input  wire logic        cmdWrite,
  input  wire logic [7:0]  cmdData,
  input  wire logic        cmdPecBad,
  input  wire logic        cmdDataBad,
  output logic             cmdReady,
  output logic             rspValid,
  output logic [15:0]      rspData,
  // Crossing to system clock
  output logic             reqToggle,
  output logic [7:0]       holdCode,
  output logic             holdWrite,
  output logic [7:0]       holdData,
  output logic             holdPecBad,
  output logic             holdDataBad,
  input  wire logic        ackToggle,
  input  wire logic [15:0] ackData
);

  logic cmdReady_q;
  logic rspValid_q;
  logic [15:0] rspData_q;
  logic reqToggle_q;
  logic [7:0] holdCode_q;
  logic holdWrite_q;
  logic [7:0] holdData_q;
  logic holdPecBad_q;
  logic holdDataBad_q;
  logic ackMeta_q;
  logic ackSync_q;
  logic ackSeen_q;
  logic accept;
  logic ackEdge;

  assign accept  = cmdValid & cmdReady_q;
  assign ackEdge = ackSync_q ^ ackSeen_q;

  // ****************************************
  // Answer toggle synchroniser
  // ****************************************
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      ackMeta_q <= 1'b0;
      ackSync_q <= 1'b0;
      ackSeen_q <= 1'b0;
    end else begin
      ackMeta_q <= ackToggle;
      ackSync_q <= ackMeta_q;
      ackSeen_q <= ackSync_q;
    end
  end

  // ****************************************
  // Request capture, held until answered
  // ****************************************
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      reqToggle_q   <= 1'b0;
      holdCode_q    <= 8'h00;
      holdWrite_q   <= 1'b0;
      holdData_q    <= 8'h00;
      holdPecBad_q  <= 1'b0;
      holdDataBad_q <= 1'b0;
    end else if (accept) begin
      reqToggle_q   <= ~reqToggle_q;
      holdCode_q    <= cmdCode;
      holdWrite_q   <= cmdWrite;
      holdData_q    <= cmdData;
      holdPecBad_q  <= cmdPecBad;
      holdDataBad_q <= cmdDataBad;
    end
  end

  // ****************************************
  // Ready and answer
  // ****************************************
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      cmdReady_q <= 1'b1;
      rspValid_q <= 1'b0;
      rspData_q  <= 16'h0000;
    end else begin
      rspValid_q <= ackEdge;
      if (ackEdge) begin
        rspData_q  <= ackData;
        cmdReady_q <= 1'b1;
      end else if (accept) begin
        cmdReady_q <= 1'b0;
      end
    end
  end

  assign cmdReady    = cmdReady_q;
  assign rspValid    = rspValid_q;
  assign rspData     = rspData_q;
  assign reqToggle   = reqToggle_q;
  assign holdCode    = holdCode_q;
  assign holdWrite   = holdWrite_q;
  assign holdData    = holdData_q;
  assign holdPecBad  = holdPecBad_q;
  assign holdDataBad = holdDataBad_q;

endmodule

`default_nettype wire

// ### logic/pstr_status_telemetry.sv
// Purpose: Status bytes and linear telemetry readbacks of a power converter
// Assumes: Monitor inputs are on sysClk; command port is on linkClk
// Notes:   Alert pin is open drain, driven low while any unmasked temperature or comm flag, or vendor bit 7 or 1, stands
`timescale 1ns/1ps
`default_nettype none
`include "pstr_regs.svh"

module pstr_status_telemetry #(
  parameter int FSM_BITS = 8
) (
  // Clocks and reset
  input  wire logic                sysClk,
  input  wire logic                linkClk,
  input  wire logic                rst,
  // Command port on linkClk
  input  wire logic                cmdValid,
  input  wire logic [7:0]          cmdCode,
  input  wire logic                cmdWrite,
  input  wire logic [7:0]          cmdData,
  input  wire logic                cmdPecBad,
  input  wire logic                cmdDataBad,
  output logic                     cmdReady,
  output logic                     rspValid,
  output logic [15:0]              rspData,
  // Temperature monitor
  input  wire logic signed [10:0]  extTempValue,
  input  wire logic signed [10:0]  ext_temp_fault_threshold,
  input  wire logic signed [10:0]  ext_temp_warn_threshold,
  // Converter events and levels
  input  wire logic                memFaultEvent,
  input  wire logic                otherCommEvent,
  input  wire logic                thermal_shutdown,
  input  wire logic [FSM_BITS-1:0] fsmStateBits,
  input  wire logic                voltageStrapBad,
  input  wire logic                softstartStrapBad,
  input  wire logic                minVoltageEvent,
  input  wire logic                syncResetPin_n,
  // Telemetry
  input  wire logic [15:0]         voutMantissa,
  input  wire logic signed [11:0]  ioutCounts,
  // Nonvolatile alert masks, 1 blocks the alert
  input  wire logic [7:0]          tempAlertMask,
  input  wire logic [7:0]          cmlAlertMask,
  input  wire logic [7:0]          vendorAlertMask,
  // Alert pin
  output logic                     smbAlertOut,
  output logic                     smbAlertOe
);

  // ****************************************
  // Declarations
  // ****************************************
  logic        reqToggle;
  logic [7:0]  holdCode;
  logic        holdWrite;
  logic [7:0]  holdData;
  logic        holdPecBad;
  logic        holdDataBad;
  logic        reqMeta_q;
  logic        reqSync_q;
  logic        reqSeen_q;
  logic        reqEdge;
  logic        ackToggle_q;
  logic [15:0] ackData_q;
  logic        pinMeta_q;
  logic        pinSync_q;
  logic        faultTrip_q;
  logic        warnTrip_q;
  logic [7:0]  tempStat_q;
  logic [7:0]  cmlStat_q;
  logic [7:0]  vendorStat_q;
  logic [15:0] voutRb_q;
  logic [15:0] ioutRb_q;
  logic [15:0] tempRb_q;
  logic        alertOe_q;
  logic        alertOut_q;
  pstr_pkg::pstr_sel_type sel;
  logic        wrOk;
  logic        clearAll;
  logic        evIvc;
  logic        evIvd;
  logic        evPec;
  logic [7:0]  tempSet;
  logic [7:0]  tempClr;
  logic [7:0]  cmlSet;
  logic [7:0]  cmlClr;
  logic [7:0]  vendorSet;
  logic [7:0]  vendorClr;
  logic signed [11:0] tempWide;
  logic signed [11:0] faultWide;
  logic signed [11:0] warnWide;
  logic [9:0]  ioutMant;
  logic [$clog2(FSM_BITS+1)-1:0] hotCount;

  // ****************************************
  // Link end
  // ****************************************
  pstr_link_port u_link (
    .linkClk     (linkClk),
    .rst         (rst),
    .cmdValid    (cmdValid),
    .cmdCode     (cmdCode),
    .cmdWrite    (cmdWrite),
    .cmdData     (cmdData),
    .cmdPecBad   (cmdPecBad),
    .cmdDataBad  (cmdDataBad),
    .cmdReady    (cmdReady),
    .rspValid    (rspValid),
    .rspData     (rspData),
    .reqToggle   (reqToggle),
    .holdCode    (holdCode),
    .holdWrite   (holdWrite),
    .holdData    (holdData),
    .holdPecBad  (holdPecBad),
    .holdDataBad (holdDataBad),
    .ackToggle   (ackToggle_q),
    .ackData     (ackData_q)
  );

  // ****************************************
  // Synchronisers
  // ****************************************
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      reqMeta_q <= 1'b0;
      reqSync_q <= 1'b0;
      reqSeen_q <= 1'b0;
      pinMeta_q <= 1'b1;
      pinSync_q <= 1'b1;
    end else begin
      reqMeta_q <= reqToggle;
      reqSync_q <= reqMeta_q;
      reqSeen_q <= reqSync_q;
      pinMeta_q <= syncResetPin_n;
      pinSync_q <= pinMeta_q;
    end
  end

  assign reqEdge = reqSync_q ^ reqSeen_q;

  // ****************************************
  // Command decode
  // ****************************************
  always_comb begin
    case (holdCode)
      `PSTR_CMD_CLEAR_FAULTS:    sel = pstr_pkg::PSTR_SEL_CLEAR;
      `PSTR_CMD_EXT_TEMP_STATUS: sel = pstr_pkg::PSTR_SEL_TEMP;
      `PSTR_CMD_COMM_FAULT:      sel = pstr_pkg::PSTR_SEL_CML;
      `PSTR_CMD_VENDOR_FAULT:    sel = pstr_pkg::PSTR_SEL_VENDOR;
      `PSTR_CMD_VOUT_READBACK:   sel = pstr_pkg::PSTR_SEL_VOUT;
      `PSTR_CMD_IOUT_READBACK:   sel = pstr_pkg::PSTR_SEL_IOUT;
      `PSTR_CMD_TEMP_READBACK:   sel = pstr_pkg::PSTR_SEL_TRB;
      default:                   sel = pstr_pkg::PSTR_SEL_NONE;
    endcase
  end

  // Writes act only when the packet PEC checked out; a data-bad flag does not block them
  assign wrOk     = reqEdge & holdWrite & ~holdPecBad;
  assign clearAll = wrOk & (sel == pstr_pkg::PSTR_SEL_CLEAR);
  // Unknown codes, and writes to readbacks, are unsupported commands
  assign evIvc = reqEdge & ((sel == pstr_pkg::PSTR_SEL_NONE) |
                 (holdWrite & (sel == pstr_pkg::PSTR_SEL_VOUT ||
                  sel == pstr_pkg::PSTR_SEL_IOUT || sel == pstr_pkg::PSTR_SEL_TRB)));
  assign evIvd = reqEdge & holdDataBad;
  assign evPec = reqEdge & holdPecBad;

  // ****************************************
  // Temperature thresholds with hysteresis
  // ****************************************
  assign tempWide  = 12'(extTempValue);
  assign faultWide = 12'(ext_temp_fault_threshold);
  assign warnWide  = 12'(ext_temp_warn_threshold);

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      faultTrip_q <= 1'b0;
      warnTrip_q  <= 1'b0;
    end else begin
      if (tempWide >= faultWide) begin
        faultTrip_q <= 1'b1;
      end else if (tempWide <= faultWide - $signed(`PSTR_TEMP_HYST_DEGC)) begin
        faultTrip_q <= 1'b0;
      end
      if (tempWide >= warnWide) begin
        warnTrip_q <= 1'b1;
      end else if (tempWide <= warnWide - $signed(`PSTR_TEMP_HYST_DEGC)) begin
        warnTrip_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Set and clear vectors
  // ****************************************
  assign hotCount = ($clog2(FSM_BITS+1))'($countones(fsmStateBits));

  always_comb begin
    tempSet = `PSTR_STATUS_RESET;
    tempSet[`PSTR_TEMP_FAULT_BIT] = faultTrip_q | (tempWide >= faultWide);
    tempSet[`PSTR_TEMP_WARN_BIT]  = warnTrip_q | (tempWide >= warnWide);
    cmlSet = `PSTR_STATUS_RESET;
    cmlSet[`PSTR_CML_IVC_BIT] = evIvc;
    cmlSet[`PSTR_CML_IVD_BIT] = evIvd;
    cmlSet[`PSTR_CML_PEC_BIT] = evPec;
    cmlSet[`PSTR_CML_MEM_BIT] = memFaultEvent;
    cmlSet[`PSTR_CML_OTH_BIT] = otherCommEvent;
    vendorSet = `PSTR_STATUS_RESET;
    vendorSet[`PSTR_VND_TSD_BIT]    = thermal_shutdown;
    vendorSet[`PSTR_VND_ZERO_BIT]   = (hotCount == '0);
    vendorSet[`PSTR_VND_MULTI_BIT]  = (hotCount > 1);
    vendorSet[`PSTR_VND_VSTRAP_BIT] = voltageStrapBad;
    vendorSet[`PSTR_VND_SSTRAP_BIT] = softstartStrapBad;
    vendorSet[`PSTR_VND_VMIN_BIT]   = minVoltageEvent;
  end

  always_comb begin
    tempClr   = `PSTR_STATUS_RESET;
    cmlClr    = `PSTR_STATUS_RESET;
    vendorClr = `PSTR_STATUS_RESET;
    if (wrOk && sel == pstr_pkg::PSTR_SEL_TEMP) begin
      tempClr = holdData & `PSTR_TEMP_W1C_MASK;
    end
    if (wrOk && sel == pstr_pkg::PSTR_SEL_CML) begin
      cmlClr = holdData & `PSTR_CML_W1C_MASK;
    end
    if (wrOk && sel == pstr_pkg::PSTR_SEL_VENDOR) begin
      vendorClr = holdData & `PSTR_VND_W1C_MASK;
    end
    if (clearAll) begin
      tempClr   = `PSTR_TEMP_W1C_MASK;
      cmlClr    = `PSTR_CML_W1C_MASK;
      vendorClr = `PSTR_VND_CLRALL_MASK;
    end
  end

  // ****************************************
  // Status bytes, set wins over clear
  // ****************************************
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      tempStat_q <= `PSTR_STATUS_RESET;
    end else begin
      tempStat_q <= (tempStat_q & ~tempClr) | tempSet;
    end
  end

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      cmlStat_q <= `PSTR_STATUS_RESET;
    end else begin
      cmlStat_q <= (cmlStat_q & ~cmlClr) | cmlSet;
    end
  end

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      vendorStat_q <= `PSTR_STATUS_RESET;
    end else begin
      vendorStat_q <= (vendorStat_q & ~vendorClr) | vendorSet;
      vendorStat_q[`PSTR_VND_RSTREQ_BIT] <= ~pinSync_q;
    end
  end

  // ****************************************
  // Telemetry readbacks
  // ****************************************
  always_comb begin
    if (ioutCounts < 0) begin
      ioutMant = 10'h000;
    end else if (ioutCounts > $signed(`PSTR_IOUT_MAX_COUNTS)) begin
      ioutMant = 10'(`PSTR_IOUT_MAX_COUNTS);
    end else begin
      ioutMant = ioutCounts[9:0];
    end
  end

  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      voutRb_q <= `PSTR_VOUT_RESET;
      ioutRb_q <= {`PSTR_IOUT_EXPONENT, 11'h000};
      tempRb_q <= {`PSTR_TEMP_EXPONENT, `PSTR_TEMP_RESET_MANT};
    end else begin
      voutRb_q <= voutMantissa;
      ioutRb_q <= {`PSTR_IOUT_EXPONENT, 1'b0, ioutMant};
      tempRb_q <= {`PSTR_TEMP_EXPONENT, extTempValue};
    end
  end

  // ****************************************
  // Answer to the link
  // ****************************************
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      ackToggle_q <= 1'b0;
      ackData_q   <= 16'h0000;
    end else if (reqEdge) begin
      ackToggle_q <= ~ackToggle_q;
      if (holdWrite) begin
        ackData_q <= 16'h0000;
      end else begin
        case (sel)
          pstr_pkg::PSTR_SEL_TEMP:   ackData_q <= {8'h00, tempStat_q};
          pstr_pkg::PSTR_SEL_CML:    ackData_q <= {8'h00, cmlStat_q};
          pstr_pkg::PSTR_SEL_VENDOR: ackData_q <= {8'h00, vendorStat_q};
          pstr_pkg::PSTR_SEL_VOUT:   ackData_q <= voutRb_q;
          pstr_pkg::PSTR_SEL_IOUT:   ackData_q <= ioutRb_q;
          pstr_pkg::PSTR_SEL_TRB:    ackData_q <= tempRb_q;
          default:                   ackData_q <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************
  // Alert pin
  // ****************************************
  always_ff @(posedge sysClk or posedge rst) begin
    if (rst) begin
      alertOe_q  <= 1'b0;
      alertOut_q <= 1'b0;
    end else begin
      alertOut_q <= 1'b0;
      alertOe_q  <= |(tempStat_q & `PSTR_TEMP_ALERT_MASK & ~tempAlertMask) |
                    |(cmlStat_q & `PSTR_CML_ALERT_MASK & ~cmlAlertMask) |
                    |(vendorStat_q & `PSTR_VND_ALERT_MASK & ~vendorAlertMask);
    end
  end

  assign smbAlertOut = alertOut_q;
  assign smbAlertOe  = alertOe_q;

endmodule

`default_nettype wire

// ### tb/pstr_host_model.sv
// Purpose: Host model issuing commands on the link port
// Assumes: One command outstanding at a time
// Notes:   Alternates prompt and slow issue of requests
`timescale 1ns/1ps
`default_nettype none
module pstr_host_model (
  // Link side
  input  wire logic        linkClk,
  input  wire logic        cmdReady,
  input  wire logic        rspValid,
  input  wire logic [15:0] rspData,
  output logic             cmdValid,
  output logic [7:0]       cmdCode,
  output logic             cmdWrite,
  output logic [7:0]       cmdData,
  output logic             cmdPecBad,
  output logic             cmdDataBad
);
  int gap = 0;
  initial begin
    {cmdValid, cmdWrite, cmdPecBad, cmdDataBad} = 4'h0;
    cmdCode = 8'hA5;
    cmdData = 8'h5A;
  end
  task automatic xfer(input logic [7:0] c, input logic w, input logic [7:0] d,
                      input logic [1:0] bad, output logic [15:0] r);
    int n;
    repeat (gap + 1) @(posedge linkClk);
    cmdValid <= 1'h1;
    cmdCode <= c;
    cmdWrite <= w;
    cmdData <= d;
    {cmdPecBad, cmdDataBad} <= bad;
    @(posedge linkClk);
    for (n = 0; n < 40 && cmdReady !== 1'h1; n++) @(posedge linkClk);
    cmdValid <= 1'h0;
    cmdCode <= ~c;
    cmdData <= ~d;
    {cmdPecBad, cmdDataBad} <= 2'h0;
    @(posedge linkClk);
    for (n = 0; n < 40 && rspValid !== 1'h1; n++) @(posedge linkClk);
    r = (rspValid === 1'h1) ? rspData : 'x;
    gap = 3 - gap;
  endtask
endmodule
`default_nettype wire

// ### tb/pstr_status_telemetry_chk.sv
// Purpose: Port-level assertions for the status and telemetry bank
// Assumes: Bound to the top module
// Notes:   Answers are judged against the last accepted command
`timescale 1ns/1ps
`default_nettype none
module pstr_status_telemetry_chk (
  // Clocks and reset
  input wire logic        sysClk,
  input wire logic        linkClk,
  input wire logic        rst,
  // Command port
  input wire logic        cmdValid,
  input wire logic [7:0]  cmdCode,
  input wire logic        cmdWrite,
  input wire logic        cmdReady,
  input wire logic        rspValid,
  input wire logic [15:0] rspData,
  // Alert
  input wire logic        thermal_shutdown,
  input wire logic [7:0]  vendorAlertMask,
  input wire logic        smbAlertOe
);
  logic [7:0] lastCode_q;
  logic       lastWrite_q;
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      lastCode_q <= 8'h00;
      lastWrite_q <= 1'h0;
    end else if (cmdValid && cmdReady) begin
      lastCode_q <= cmdCode;
      lastWrite_q <= cmdWrite;
    end
  end
  // ****************
  // Assertions
  // ****************
  a_take_drops_ready: assert property (@(posedge linkClk) disable iff (rst)
    cmdValid && cmdReady |=> !cmdReady) else $error("ready held after take");
  a_answer_in_time: assert property (@(posedge linkClk) disable iff (rst)
    cmdValid && cmdReady |-> ##[3:12] rspValid) else $error("answer late");
  a_answer_one_pulse: assert property (@(posedge linkClk) disable iff (rst)
    rspValid |-> cmdReady ##1 !rspValid) else $error("answer pulse wrong");
  a_write_answer_zero: assert property (@(posedge linkClk) disable iff (rst)
    rspValid && lastWrite_q |-> rspData == 16'h0000) else $error("write answer");
  a_status_upper_zero: assert property (@(posedge linkClk) disable iff (rst)
    rspValid && !lastWrite_q && lastCode_q inside {8'h7D, 8'h7E, 8'h80}
    |-> rspData[15:8] == 8'h00) else $error("status upper byte");
  a_iout_word_form: assert property (@(posedge linkClk) disable iff (rst)
    rspValid && !lastWrite_q && lastCode_q == 8'h8C
    |-> rspData[15:10] == 6'h38 && rspData[9:0] <= 10'h280) else $error("current word");
  a_temp_exp_zero: assert property (@(posedge linkClk) disable iff (rst)
    rspValid && !lastWrite_q && lastCode_q == 8'h8E
    |-> rspData[15:11] == 5'h00) else $error("temperature exponent");
  a_unknown_reads_zero: assert property (@(posedge linkClk) disable iff (rst)
    rspValid && !(lastCode_q inside {8'h03, 8'h7D, 8'h7E, 8'h80, 8'h8B, 8'h8C, 8'h8E})
    |-> rspData == 16'h0000) else $error("unknown code answer");
  a_tsd_raises_alert: assert property (@(posedge sysClk) disable iff (rst)
    thermal_shutdown && !vendorAlertMask[7] |-> ##[1:3] smbAlertOe) else $error("no alert");
  c_iout_read: cover property (@(posedge linkClk) rspValid && lastCode_q == 8'h8C);
  c_alert_rise: cover property (@(posedge sysClk) $rose(smbAlertOe));
  c_write_done: cover property (@(posedge linkClk) rspValid && lastWrite_q);
endmodule
bind pstr_status_telemetry pstr_status_telemetry_chk u_pstr_status_telemetry_chk (
  .sysClk(sysClk), .linkClk(linkClk), .rst(rst), .cmdValid(cmdValid), .cmdCode(cmdCode),
  .cmdWrite(cmdWrite), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
  .thermal_shutdown(thermal_shutdown), .vendorAlertMask(vendorAlertMask),
  .smbAlertOe(smbAlertOe));
`default_nettype wire

// ### tb/tb.sv
// Purpose: Self-checking bench for the status and telemetry bank
// Assumes: Host model drives the command port on linkClk
// Notes:   Expected words are built here from the field layout
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic               sysClk = 1'h0, linkClk = 1'h0, rst = 1'h1;
  logic signed [10:0] extTempValue = 11'h019;
  logic signed [10:0] ext_temp_fault_threshold = 11'h064, ext_temp_warn_threshold = 11'h050;
  logic               memFaultEvent = 1'h0, otherCommEvent = 1'h0, thermal_shutdown = 1'h0;
  logic               voltageStrapBad = 1'h0, softstartStrapBad = 1'h0, minVoltageEvent = 1'h0;
  logic               syncResetPin_n = 1'h1, smbAlertOut;
  logic [7:0]         fsmStateBits = 8'h01;
  logic [15:0]        voutMantissa = 16'h1234;
  logic signed [11:0] ioutCounts = 12'h000;
  logic [7:0]         tempAlertMask = 8'h00, cmlAlertMask = 8'h00, vendorAlertMask = 8'h00;
  logic               cmdValid, cmdWrite, cmdPecBad, cmdDataBad, cmdReady, rspValid, smbAlertOe;
  logic [7:0]         cmdCode, cmdData;
  logic [15:0]        rspData, rd;
  logic [11:0]        iv[5] = '{12'hFFB, 12'h064, 12'h280, 12'h281, 12'h7FF};
  logic [9:0]         ie[5] = '{10'h000, 10'h064, 10'h280, 10'h280, 10'h280};
  int                 miscompares = 0, tests_run = 0, cycles = 0;
  always #2 sysClk = ~sysClk;
  initial begin
    #1.3;
    forever #7.5 linkClk = ~linkClk;
  end
  pstr_status_telemetry #(.FSM_BITS(8)) u_pstr_status_telemetry (
    .sysClk(sysClk), .linkClk(linkClk), .rst(rst), .cmdValid(cmdValid), .cmdCode(cmdCode),
    .cmdWrite(cmdWrite), .cmdData(cmdData), .cmdPecBad(cmdPecBad), .cmdDataBad(cmdDataBad),
    .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData), .extTempValue(extTempValue),
    .ext_temp_fault_threshold(ext_temp_fault_threshold),
    .ext_temp_warn_threshold(ext_temp_warn_threshold), .memFaultEvent(memFaultEvent),
    .otherCommEvent(otherCommEvent), .thermal_shutdown(thermal_shutdown),
    .fsmStateBits(fsmStateBits), .voltageStrapBad(voltageStrapBad),
    .softstartStrapBad(softstartStrapBad), .minVoltageEvent(minVoltageEvent),
    .syncResetPin_n(syncResetPin_n), .voutMantissa(voutMantissa), .ioutCounts(ioutCounts),
    .tempAlertMask(tempAlertMask), .cmlAlertMask(cmlAlertMask),
    .vendorAlertMask(vendorAlertMask), .smbAlertOut(smbAlertOut), .smbAlertOe(smbAlertOe));
  pstr_host_model u_pstr_host_model (
    .linkClk(linkClk), .cmdReady(cmdReady), .rspValid(rspValid), .rspData(rspData),
    .cmdValid(cmdValid), .cmdCode(cmdCode), .cmdWrite(cmdWrite), .cmdData(cmdData),
    .cmdPecBad(cmdPecBad), .cmdDataBad(cmdDataBad));
  // ****************
  // Tasks
  // ****************
  task automatic close_out;
    if (miscompares == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic syc(input int n);
    repeat (n) @(posedge sysClk);
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] exp);
    u_pstr_host_model.xfer(c, 1'h0, 8'h00, 2'h0, rd);
    chk(rd, exp);
  endtask
  task automatic wrc(input logic [7:0] c, input logic [7:0] d, input logic [1:0] bad);
    u_pstr_host_model.xfer(c, 1'h1, d, bad, rd);
    chk(rd, 16'h0000);
  endtask
  task automatic alert(input logic exp);
    syc(4);
    chk({14'h0000, smbAlertOut, smbAlertOe}, {15'h0000, exp});
  endtask
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      $display("[ERR] %0t run timed out", $time);
      close_out;
    end
  end
  // ****************
  // Tests
  // ****************
  initial begin
    syc(10);
    rst <= 1'h0;
    syc(2);
    rdc(8'h7D, 16'h0000);
    rdc(8'h7E, 16'h0000);
    rdc(8'h80, 16'h0000);
    rdc(8'h8B, 16'h1234);
    rdc(8'h8E, 16'h0019);
    wrc(8'h8B, 8'h55, 2'h0);
    rdc(8'h8B, 16'h1234);
    rdc(8'h55, 16'h0000);
    rdc(8'h7E, 16'h0080);
    for (int i = 0; i < 5; i++) begin
      syc(1);
      ioutCounts <= iv[i];
      syc(3);
      rdc(8'h8C, {6'h38, ie[i]});
    end
    wrc(8'h7D, 8'h00, 2'h1);
    wrc(8'h7E, 8'hFF, 2'h2);
    syc(1);
    {memFaultEvent, otherCommEvent} <= 2'h3;
    syc(1);
    {memFaultEvent, otherCommEvent} <= 2'h0;
    rdc(8'h7E, 16'h00F2);
    alert(1'h1);
    cmlAlertMask <= 8'hFF;
    alert(1'h0);
    cmlAlertMask <= 8'h00;
    wrc(8'h7E, 8'h80, 2'h0);
    rdc(8'h7E, 16'h0072);
    wrc(8'h7E, 8'hFF, 2'h0);
    rdc(8'h7E, 16'h0000);
    syc(1);
    extTempValue <= 11'h064;
    syc(3);
    rdc(8'h7D, 16'h00C0);
    syc(1);
    extTempValue <= 11'h051;
    syc(3);
    wrc(8'h7D, 8'hC0, 2'h0);
    rdc(8'h7D, 16'h00C0);
    syc(1);
    extTempValue <= 11'h050;
    syc(3);
    wrc(8'h7D, 8'hC0, 2'h0);
    rdc(8'h7D, 16'h0040);
    rdc(8'h8E, 16'h0050);
    syc(1);
    tempAlertMask <= 8'hFF;
    alert(1'h0);
    tempAlertMask <= 8'h00;
    extTempValue <= 11'h03C;
    syc(3);
    wrc(8'h7D, 8'hC0, 2'h0);
    rdc(8'h7D, 16'h0000);
    syc(1);
    {thermal_shutdown, voltageStrapBad, softstartStrapBad, minVoltageEvent} <= 4'hF;
    syncResetPin_n <= 1'h0;
    fsmStateBits <= 8'h00;
    syc(2);
    {thermal_shutdown, voltageStrapBad, softstartStrapBad, minVoltageEvent} <= 4'h0;
    fsmStateBits <= 8'h03;
    syc(2);
    fsmStateBits <= 8'h01;
    syc(3);
    rdc(8'h80, 16'h00FE);
    syc(1);
    syncResetPin_n <= 1'h1;
    syc(4);
    wrc(8'h80, 8'hFF, 2'h0);
    rdc(8'h80, 16'h0060);
    alert(1'h0);
    syncResetPin_n <= 1'h0;
    alert(1'h0);
    rdc(8'h80, 16'h0064);
    syc(1);
    syncResetPin_n <= 1'h1;
    syc(4);
    wrc(8'h03, 8'h00, 2'h0);
    rdc(8'h80, 16'h0000);
    syc(1);
    vendorAlertMask <= 8'h80;
    thermal_shutdown <= 1'h1;
    syc(1);
    thermal_shutdown <= 1'h0;
    alert(1'h0);
    vendorAlertMask <= 8'h00;
    alert(1'h1);
    wrc(8'h80, 8'h80, 2'h0);
    alert(1'h0);
    close_out;
  end
endmodule
`default_nettype wire
